// ==== qdc_serial_control.sv ====
/*
 * Serial control logic of a quad 16-bit converter: frame capture on the
 * host serial clock, decode into per-channel registers, load/clear update,
 * readback and daisy-chain output, coding and segment decode.
 * Assumes SCLK is made by the host and may stop between frames; CLK is the
 * device's own clock; SYNC_N stays high at least four CLK periods between
 * frames so the captured word is read while the serial clock is idle.
 */
`default_nettype none

// Behaviour
// - frames are 24 bits, msb first, captured on falling serial clock edges
// - word splits into read flag, register select, channel, 16 payload bits
// - reset zeroes data registers and clamps outputs until load or clear
// - coding input low means twos complement, high means offset binary
// - frame opens on sync falling and needs exactly 24 falling clocks standalone, at least 24 chained
// - fewer than 24 falling clocks before sync rises voids the frame
// - standalone, more than 24 falling clocks voids the frame
// - sync rising moves the word into its register; next needs sync fall
// - extra clocks shift old bits out; output changes on rising edges
// - chained devices pass data on; sync rising latches all of them
// - readback needs the output-disable bit clear, cleared by reset
// - read flag set selects register and channel to read, payload ignored
// - frame after a read shifts the selected register out
// - fine gain reads back in payload bits five down to zero
// - load low during shifting updates the addressed output at sync rise
// - load high during shifting; its later fall updates all outputs
// - offset binary midscale is zero volts, steps are 1/65536 of span
// - upper four code bits make 15 segment controls, lower 12 the ladder
// - register select 000 func, 010 data, 011 coarse, 100 fine, 101 offset
// - channel codes 000 to 011 pick one channel, 100 picks all
module qdc_serial_control #(
    parameter int NUM_CH = 4
) (
    input  wire logic                               CLK,
    input  wire logic                               RST_N,
    input  wire logic                               SCLK,
    input  wire logic                               SYNC_N,
    input  wire logic                               SERIAL_IN,
    input  wire logic                               LOAD_UPDATE_N,
    input  wire logic                               CLEAR_N,
    input  wire logic                               CODING_SELECT,
    input  wire logic                               DAISY_CHAIN,
    output var  logic                               SERIAL_OUT,
    output var  logic                               SERIAL_OUT_OE,
    output var  qdc_pkg::qdc_chan_out_t [NUM_CH-1:0] CHAN_OUT,
    output var  logic [qdc_pkg::FUNC_W-1:0]         FUNC_BITS,
    output var  logic                               FRAME_DONE,
    output var  logic                               FRAME_INVALID
);

    localparam int DW = qdc_pkg::DATA_W;
    localparam int CW = qdc_pkg::CNT_W;

    // ---------------- link domain (SCLK) ----------------
    logic [qdc_pkg::FRAME_W-1:0] shift_reg;
    logic [qdc_pkg::FRAME_W-1:0] shift_next;
    logic [CW-1:0]               cnt_reg;
    logic [CW-1:0]               cnt_next;
    logic                        tog_reg;
    logic                        armed_reg;
    logic                        sdo_reg;
    logic                        link_idle;
    logic                        first_bit;

    // readback state owned by the CLK domain, read by the link at frame start
    logic [qdc_pkg::FRAME_W-1:0] rb_word_reg;
    logic                        rb_load_reg;
    logic [qdc_pkg::FUNC_W-1:0]  func_reg;

    assign link_idle = SYNC_N | ~RST_N;

    // armed until the first falling clock of a frame
    always_ff @(negedge SCLK or posedge link_idle) begin
        if (link_idle) begin
            armed_reg <= 1'b1;
        end else begin
            armed_reg <= 1'b0;
        end
    end

    assign shift_next = (armed_reg && rb_load_reg) ?
                        {rb_word_reg[qdc_pkg::FRAME_W-2:0], SERIAL_IN} :
                        {shift_reg[qdc_pkg::FRAME_W-2:0], SERIAL_IN};
    assign cnt_next   = armed_reg ? qdc_pkg::CNT_ONE :
                        (cnt_reg == qdc_pkg::CNT_MAX) ? cnt_reg :
                        cnt_reg + qdc_pkg::CNT_ONE;

    // shifting stops once sync is high, freezing the word for the CLK side
    always_ff @(negedge SCLK or negedge RST_N) begin
        if (!RST_N) begin
            shift_reg <= '0;
            cnt_reg   <= '0;
            tog_reg   <= 1'b0;
        end else if (!SYNC_N) begin
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
            if (armed_reg) begin
                tog_reg <= ~tog_reg;
            end
        end
    end

    always_ff @(posedge SCLK or negedge RST_N) begin
        if (!RST_N) begin
            sdo_reg <= 1'b0;
        end else if (!SYNC_N) begin
            sdo_reg <= shift_reg[qdc_pkg::FRAME_W-1];
        end
    end

    // before the first falling edge the msb to go out must already stand
    assign first_bit = rb_load_reg ? rb_word_reg[qdc_pkg::FRAME_W-1] :
                                     shift_reg[qdc_pkg::FRAME_W-1];
    assign SERIAL_OUT    = armed_reg ? first_bit : sdo_reg;
    assign SERIAL_OUT_OE = ~func_reg[qdc_pkg::SDO_DIS_BIT] & ~SYNC_N;

    // ---------------- device domain (CLK) ----------------
    logic [qdc_pkg::PIN_N-1:0] pin_raw;
    logic [qdc_pkg::PIN_N-1:0] pin_meta_reg;
    logic [qdc_pkg::PIN_N-1:0] pin_sync_reg;
    logic [qdc_pkg::PIN_N-1:0] pin_prev_reg;

    assign pin_raw = {DAISY_CHAIN, CODING_SELECT, CLEAR_N, LOAD_UPDATE_N,
                      SYNC_N};

    genvar p;
    generate
        for (p = 0; p < qdc_pkg::PIN_N; p++) begin : g_pin
            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    pin_meta_reg[p] <= 1'b1;
                    pin_sync_reg[p] <= 1'b1;
                    pin_prev_reg[p] <= 1'b1;
                end else begin
                    pin_meta_reg[p] <= pin_raw[p];
                    pin_sync_reg[p] <= pin_meta_reg[p];
                    pin_prev_reg[p] <= pin_sync_reg[p];
                end
            end
        end
    endgenerate

    logic sync_rise;
    logic load_fall;
    logic clear_fall;
    logic load_low;
    logic clear_low;
    logic chain_mode;
    logic offset_binary;

    assign sync_rise     = pin_sync_reg[qdc_pkg::PIN_SYNC] &
                           ~pin_prev_reg[qdc_pkg::PIN_SYNC];
    assign load_fall     = ~pin_sync_reg[qdc_pkg::PIN_LOAD] &
                           pin_prev_reg[qdc_pkg::PIN_LOAD];
    assign clear_fall    = ~pin_sync_reg[qdc_pkg::PIN_CLEAR] &
                           pin_prev_reg[qdc_pkg::PIN_CLEAR];
    assign load_low      = ~pin_sync_reg[qdc_pkg::PIN_LOAD];
    assign clear_low     = ~pin_sync_reg[qdc_pkg::PIN_CLEAR];
    assign chain_mode    = pin_sync_reg[qdc_pkg::PIN_CHAIN];
    assign offset_binary = pin_sync_reg[qdc_pkg::PIN_CODING];

    // frame acceptance; link state is frozen while sync is high
    logic                seen_tog_reg;
    logic                clocks_seen;
    logic                count_ok;
    logic                frame_ok;
    qdc_pkg::qdc_frame_t frame;

    assign frame       = qdc_pkg::qdc_frame_t'(shift_reg);
    assign clocks_seen = tog_reg ^ seen_tog_reg;
    assign count_ok    = chain_mode ? (cnt_reg >= qdc_pkg::CNT_FRAME) :
                                      (cnt_reg == qdc_pkg::CNT_FRAME);
    assign frame_ok    = sync_rise & clocks_seen & count_ok;

    // decoded write strobes
    logic wr;
    logic wr_data;
    logic wr_coarse;
    logic wr_fine;
    logic wr_offset;
    logic wr_ctrl;
    logic sw_clear;
    logic sw_load;
    logic do_clear;
    logic do_load_all;

    assign wr        = frame_ok & ~frame.rw;
    assign wr_data   = wr & (frame.register_select == qdc_pkg::REG_DATA);
    assign wr_coarse = wr & (frame.register_select == qdc_pkg::REG_COARSE);
    assign wr_fine   = wr & (frame.register_select == qdc_pkg::REG_FINE);
    assign wr_offset = wr & (frame.register_select == qdc_pkg::REG_OFFSET);
    assign wr_ctrl   = wr & (frame.register_select == qdc_pkg::REG_FUNC) &
                       (frame.channel_select == qdc_pkg::FN_CTRL);
    assign sw_clear  = wr & (frame.register_select == qdc_pkg::REG_FUNC) &
                       (frame.channel_select == qdc_pkg::FN_CLEAR);
    assign sw_load   = wr & (frame.register_select == qdc_pkg::REG_FUNC) &
                       (frame.channel_select == qdc_pkg::FN_LOAD);
    assign do_clear    = clear_fall | sw_clear;
    assign do_load_all = load_fall | sw_load;

    // per-channel storage
    logic [DW-1:0]                input_reg  [NUM_CH];
    logic [DW-1:0]                dac_reg    [NUM_CH];
    logic [qdc_pkg::COARSE_W-1:0] coarse_reg [NUM_CH];
    logic [qdc_pkg::FINE_W-1:0]   fine_reg   [NUM_CH];
    logic [qdc_pkg::OFFSET_W-1:0] offset_reg [NUM_CH];
    logic                         clamp_reg;
    logic [NUM_CH-1:0]            ch_hit;

    genvar c;
    genvar s;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            localparam int       SEG_CNT = qdc_pkg::SEG_N;
            logic [DW-1:0]       straight;
            logic [DW-1:0]       dac_next;
            logic [DW-1:0]       input_next;
            logic [SEG_CNT-1:0]  seg;

            assign ch_hit[c] = (frame.channel_select == 3'(c)) |
                               (frame.channel_select == qdc_pkg::CH_ALL);

            assign input_next = do_clear ? qdc_pkg::ZERO_CODE :
                                (wr_data && ch_hit[c]) ? frame.data :
                                input_reg[c];
            assign dac_next   = do_clear ? qdc_pkg::ZERO_CODE :
                                do_load_all ? input_reg[c] :
                                (wr_data && ch_hit[c] && load_low) ?
                                frame.data : dac_reg[c];

            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    input_reg[c]  <= qdc_pkg::ZERO_CODE;
                    dac_reg[c]    <= qdc_pkg::ZERO_CODE;
                    coarse_reg[c] <= '0;
                    fine_reg[c]   <= '0;
                    offset_reg[c] <= '0;
                end else begin
                    input_reg[c] <= input_next;
                    dac_reg[c]   <= dac_next;
                    if (wr_coarse && ch_hit[c]) begin
                        coarse_reg[c] <= frame.data[qdc_pkg::COARSE_W-1:0];
                    end
                    if (wr_fine && ch_hit[c]) begin
                        fine_reg[c] <= frame.data[qdc_pkg::FINE_W-1:0];
                    end
                    if (wr_offset && ch_hit[c]) begin
                        offset_reg[c] <= frame.data[qdc_pkg::OFFSET_W-1:0];
                    end
                end
            end

            // core sees straight binary: twos complement gets its msb flipped
            assign straight = offset_binary ? dac_reg[c] :
                              dac_reg[c] ^ qdc_pkg::SIGN_FLIP;

            for (s = 0; s < SEG_CNT; s++) begin : g_seg
                assign seg[s] = straight[DW-1 -: qdc_pkg::SEG_W] >
                                qdc_pkg::SEG_W'(s);
            end

            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    CHAN_OUT[c] <= '{clamp: 1'b1, default: '0};
                end else begin
                    CHAN_OUT[c].clamp            <= clamp_reg;
                    CHAN_OUT[c].code             <= straight;
                    CHAN_OUT[c].segment_switches <= seg;
                    CHAN_OUT[c].ladder_switches  <=
                        straight[qdc_pkg::LADDER_W-1:0];
                    CHAN_OUT[c].coarse_gain      <= coarse_reg[c];
                    CHAN_OUT[c].fine_gain        <= fine_reg[c];
                    CHAN_OUT[c].offset           <= offset_reg[c];
                end
            end
        end
    endgenerate

    // readback selection; channel code 100 reads channel A
    logic [1:0]    rb_ch;
    logic [DW-1:0] rb_value;
    logic          rd;

    assign rd    = frame_ok & frame.rw;
    assign rb_ch = frame.channel_select[1:0];
    assign rb_value =
        (frame.register_select == qdc_pkg::REG_DATA)   ? input_reg[rb_ch] :
        (frame.register_select == qdc_pkg::REG_COARSE) ?
            DW'(coarse_reg[rb_ch]) :
        (frame.register_select == qdc_pkg::REG_FINE)   ?
            DW'(fine_reg[rb_ch]) :
        (frame.register_select == qdc_pkg::REG_OFFSET) ?
            DW'(offset_reg[rb_ch]) :
        (frame.register_select == qdc_pkg::REG_FUNC)   ?
            DW'(func_reg) : qdc_pkg::ZERO_CODE;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            seen_tog_reg <= 1'b0;
            rb_word_reg  <= '0;
            rb_load_reg  <= 1'b0;
        end else if (sync_rise) begin
            seen_tog_reg <= tog_reg;
            rb_load_reg  <= rd;
            if (rd) begin
                rb_word_reg <= {shift_reg[qdc_pkg::FRAME_W-1 -:
                                          qdc_pkg::HDR_W], rb_value};
            end
        end
    end

    // clamp holds until load or clear is asserted
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            clamp_reg <= 1'b1;
        end else if (load_low || clear_low || sw_clear || sw_load) begin
            clamp_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            func_reg <= qdc_pkg::FUNC_RESET;
        end else if (wr_ctrl) begin
            func_reg <= frame.data[qdc_pkg::FUNC_W-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            FRAME_DONE    <= 1'b0;
            FRAME_INVALID <= 1'b0;
        end else begin
            FRAME_DONE    <= frame_ok;
            FRAME_INVALID <= sync_rise & ~frame_ok;
        end
    end

    assign FUNC_BITS = func_reg;

endmodule : qdc_serial_control

`default_nettype wire

// ==== qdc_pkg.sv ====
/*
 * Shared constants and carrier types for the quad converter serial control.
 * Assumes a 24-bit framed serial word and four converter channels.
 */
`default_nettype none

package qdc_pkg;

    // frame layout
    localparam int          FRAME_W      = 24;
    localparam int          RW_BIT       = 23;
    localparam int          REG_HI       = 21;
    localparam int          REG_LO       = 19;
    localparam int          CH_HI        = 18;
    localparam int          CH_LO        = 16;
    localparam int          DATA_W       = 16;
    localparam int          HDR_W        = 8;

    // frame bit counter, saturating so long chains cannot wrap
    localparam int          CNT_W        = 5;
    localparam logic [4:0]  CNT_FRAME    = 5'h18;
    localparam logic [4:0]  CNT_MAX      = 5'h1f;
    localparam logic [4:0]  CNT_ONE      = 5'h01;

    // register select codes
    localparam logic [2:0]  REG_FUNC     = 3'h0;
    localparam logic [2:0]  REG_DATA     = 3'h2;
    localparam logic [2:0]  REG_COARSE   = 3'h3;
    localparam logic [2:0]  REG_FINE     = 3'h4;
    localparam logic [2:0]  REG_OFFSET   = 3'h5;

    // channel codes; function register reuses the field as a sub-command
    localparam logic [2:0]  CH_ALL       = 3'h4;
    localparam logic [2:0]  FN_CTRL      = 3'h1;
    localparam logic [2:0]  FN_CLEAR     = 3'h4;
    localparam logic [2:0]  FN_LOAD      = 3'h5;

    // stored field widths and reset values
    localparam int          FUNC_W       = 6;
    localparam int          SDO_DIS_BIT  = 0;
    localparam int          COARSE_W     = 2;
    localparam int          FINE_W       = 6;
    localparam int          OFFSET_W     = 8;
    localparam logic [5:0]  FUNC_RESET   = 6'h00;
    localparam logic [15:0] ZERO_CODE    = 16'h0000;
    localparam logic [15:0] SIGN_FLIP    = 16'h8000;

    // converter core split
    localparam int          SEG_N        = 15;
    localparam int          SEG_W        = 4;
    localparam int          LADDER_W     = 12;

    // synchronised pin indices
    localparam int          PIN_N        = 5;
    localparam int          PIN_SYNC     = 0;
    localparam int          PIN_LOAD     = 1;
    localparam int          PIN_CLEAR    = 2;
    localparam int          PIN_CODING   = 3;
    localparam int          PIN_CHAIN    = 4;

    typedef struct packed {
        logic                 rw;
        logic                 zero;
        logic [2:0]           register_select;
        logic [2:0]           channel_select;
        logic [DATA_W-1:0]    data;
    } qdc_frame_t;

    typedef struct packed {
        logic                 clamp;
        logic [DATA_W-1:0]    code;
        logic [SEG_N-1:0]     segment_switches;
        logic [LADDER_W-1:0]  ladder_switches;
        logic [COARSE_W-1:0]  coarse_gain;
        logic [FINE_W-1:0]    fine_gain;
        logic [OFFSET_W-1:0]  offset;
    } qdc_chan_out_t;

endpackage : qdc_pkg

`default_nettype wire

// ==== qdc_serial_control_chk.sv ====
/* timing and value checks on the serial control top-level ports.
   assumes the single CLK domain with synchronous active-low RST_N. */
`default_nettype none
module qdc_serial_control_chk #(
    parameter int NUM_CH = 4
) (
    input wire logic                               CLK,
    input wire logic                               RST_N,
    input wire logic                               SYNC_N,
    input wire logic                               LOAD_UPDATE_N,
    input wire logic                               CLEAR_N,
    input wire logic                               CODING_SELECT,
    input wire logic                               DAISY_CHAIN,
    input wire logic                               SERIAL_OUT_OE,
    input wire qdc_pkg::qdc_chan_out_t [NUM_CH-1:0] CHAN_OUT,
    input wire logic [qdc_pkg::FUNC_W-1:0]         FUNC_BITS,
    input wire logic                               FRAME_DONE,
    input wire logic                               FRAME_INVALID
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // cycles since anything that may legally move a channel code
    logic [3:0] quiet_reg;
    logic [3:0] quiet_next;
    logic       load_q_reg;
    logic       coding_q_reg;
    logic       cause;
    logic [15:0] seg_ref;
    assign cause = FRAME_DONE | (load_q_reg & ~LOAD_UPDATE_N) | ~CLEAR_N
                 | (coding_q_reg ^ CODING_SELECT);
    assign quiet_next = cause ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hf};
    assign seg_ref = (16'h1 << CHAN_OUT[0].code[15:12]) - 16'h1;
    always_ff @(posedge CLK) begin
        load_q_reg   <= LOAD_UPDATE_N;
        coding_q_reg <= CODING_SELECT;
        quiet_reg    <= RST_N ? quiet_next : 4'h0;
    end

    pulse_excl_a: assert property (!(FRAME_DONE && FRAME_INVALID))
        else $error("done and invalid together");
    pulse_one_a: assert property ((FRAME_DONE || FRAME_INVALID) |=>
        !FRAME_DONE && !FRAME_INVALID) else $error("result pulse too long");
    after_sync_a: assert property ((FRAME_DONE || FRAME_INVALID) |->
        SYNC_N && $past(SYNC_N) && $past(SYNC_N, 2))
        else $error("result without sync rise");
    out_enable_a: assert property (SERIAL_OUT_OE ==
        (!SYNC_N && !FUNC_BITS[qdc_pkg::SDO_DIS_BIT]))
        else $error("serial output enable wrong");
    reset_state_a: assert property ($rose(RST_N) |-> CHAN_OUT[0].clamp &&
        FUNC_BITS == qdc_pkg::FUNC_RESET) else $error("reset state wrong");
    seg_decode_a: assert property (CHAN_OUT[0].segment_switches ==
        seg_ref[14:0] && CHAN_OUT[0].ladder_switches ==
        CHAN_OUT[0].code[11:0]) else $error("segment decode wrong");
    code_cause_a: assert property ($changed(CHAN_OUT[0].code) |->
        quiet_reg < 4'h8) else $error("code moved without cause");
    invalid_keep_a: assert property (FRAME_INVALID && quiet_reg > 4'h6 |=>
        $stable(CHAN_OUT[0].code) [*3]) else $error("invalid frame applied");

    cover property (FRAME_DONE && DAISY_CHAIN);
    cover property (FRAME_INVALID);
    cover property ($fell(CHAN_OUT[0].clamp));
endmodule : qdc_serial_control_chk

bind qdc_serial_control qdc_serial_control_chk #(.NUM_CH(NUM_CH)) i_chk (
    .CLK(CLK), .RST_N(RST_N), .SYNC_N(SYNC_N),
    .LOAD_UPDATE_N(LOAD_UPDATE_N), .CLEAR_N(CLEAR_N),
    .CODING_SELECT(CODING_SELECT), .DAISY_CHAIN(DAISY_CHAIN),
    .SERIAL_OUT_OE(SERIAL_OUT_OE), .CHAN_OUT(CHAN_OUT),
    .FUNC_BITS(FUNC_BITS), .FRAME_DONE(FRAME_DONE),
    .FRAME_INVALID(FRAME_INVALID));
`default_nettype wire

// ==== qdc_host_model.sv ====
/* host serial port model: gated serial clock, frame sync, data out,
   capture of the device serial output. caller times gaps between frames. */
`default_nettype none
module qdc_host_model (
    output var  logic SCLK,
    output var  logic SYNC_N,
    output var  logic SERIAL_IN,
    input  wire logic SERIAL_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        SCLK      = 1'b1;
        SYNC_N    = 1'b1;
        SERIAL_IN = 1'b0;
    end
    // sends the low n bits of w msb first with exactly n falling edges
    task automatic send(input logic [47:0] w, input int n,
                        output logic [23:0] rx);
        rx = 24'h0;
        SYNC_N = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            SERIAL_IN = w[i];
            #32;
            rx = {rx[22:0], SERIAL_OUT};
            SCLK = 1'b0;
            #32;
            SCLK = 1'b1;
        end
        #32;
        SYNC_N = 1'b1;
        SERIAL_IN = ~SERIAL_IN;
    endtask : send
endmodule : qdc_host_model
`default_nettype wire

// ==== test_quad_dac_serial_control.sv ====
/* self-checking bench for the quad converter serial control.
   assumes the host model drives the link and CLK runs at 10 MHz. */
`default_nettype none
module test_quad_dac_serial_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic                         clk, rst_n, sclk, sync_n, serial_in;
    logic                         load_update_n, clear_n, coding_select;
    logic                         daisy_chain, serial_out, serial_out_oe;
    logic                         frame_done, frame_invalid;
    qdc_pkg::qdc_chan_out_t [3:0] chan_out;
    logic [5:0]                   func_bits;
    logic [15:0]                  d, e;
    logic [23:0]                  rx;
    logic [19:0]                  notes [$];
    int                           fail_count, comparisons, seed;

    qdc_serial_control #(.NUM_CH(4)) i_dut (
        .CLK(clk), .RST_N(rst_n), .SCLK(sclk), .SYNC_N(sync_n),
        .SERIAL_IN(serial_in), .LOAD_UPDATE_N(load_update_n),
        .CLEAR_N(clear_n), .CODING_SELECT(coding_select),
        .DAISY_CHAIN(daisy_chain), .SERIAL_OUT(serial_out),
        .SERIAL_OUT_OE(serial_out_oe), .CHAN_OUT(chan_out),
        .FUNC_BITS(func_bits), .FRAME_DONE(frame_done),
        .FRAME_INVALID(frame_invalid));
    qdc_host_model i_host (.SCLK(sclk), .SYNC_N(sync_n),
        .SERIAL_IN(serial_in), .SERIAL_OUT(serial_out));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic bad(input string msg);
        fail_count++;
        $display("BAD %0t %s", $time, msg);
    endtask : bad
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) bad($sformatf("got %h want %h", got, exp));
    endtask : chk
    task automatic wrap_up;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    function automatic logic [15:0] flip(input logic [15:0] v);
        return coding_select ? v : v ^ qdc_pkg::SIGN_FLIP;
    endfunction : flip
    // note: {applied, check code, channel, straight code}
    task automatic frame(input logic [47:0] w, input int n, input logic ok,
                         input logic [1:0] ch, input logic [15:0] code,
                         input logic c);
        notes.push_back({ok, c, ch, code});
        i_host.send(w, n, rx);
        repeat (8) @(negedge clk);
        if (notes.size() != 0) begin
            bad("no frame result");
            notes.delete();
        end
    endtask : frame

    initial begin
        logic [19:0] n;
        forever begin
            @(negedge clk);
            if (frame_done === 1'b1 || frame_invalid === 1'b1) begin
                if (notes.size() == 0) begin
                    bad("unexpected frame result");
                end else begin
                    n = notes.pop_front();
                    chk({15'h0, frame_done}, {15'h0, n[19]});
                    if (n[18]) begin
                        repeat (2) @(negedge clk);
                        chk(chan_out[n[17:16]].code, n[15:0]);
                    end
                end
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad("timeout");
        wrap_up();
    end

    initial begin
        seed = 32'h72e0;
        rst_n = 1'b0;
        load_update_n = 1'b1;
        clear_n = 1'b1;
        coding_select = 1'b0;
        daisy_chain = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        for (int k = 0; k < 4; k++) chk({15'h0, chan_out[k].clamp}, 16'h1);
        chk({10'h0, func_bits}, {10'h0, qdc_pkg::FUNC_RESET});
        load_update_n = 1'b0;
        for (int i = 0; i < 8; i++) begin
            coding_select = i[2];
            repeat (4) @(negedge clk);
            d = 16'($random(seed));
            frame({24'h0, 6'h04, i[1:0], d}, 24, 1'b1, i[1:0], flip(d), 1'b1);
        end
        chk({15'h0, chan_out[0].clamp}, 16'h0);
        frame({24'h0, 8'h10, d}, 23, 1'b0, 2'h0, 16'h0, 1'b0);
        frame({24'h0, 8'h10, d}, 25, 1'b0, 2'h0, 16'h0, 1'b0);
        e = 16'($random(seed));
        frame({24'h0, 8'h14, e}, 24, 1'b1, 2'h3, flip(e), 1'b1);
        chk(chan_out[0].code, flip(e));
        load_update_n = 1'b1;
        d = 16'($random(seed));
        frame({24'h0, 8'h11, d}, 24, 1'b1, 2'h1, 16'h0, 1'b0);
        chk(chan_out[1].code, flip(e));
        load_update_n = 1'b0;
        repeat (6) @(negedge clk);
        chk(chan_out[1].code, flip(d));
        frame(48'h20_002a, 24, 1'b1, 2'h0, 16'h0, 1'b0);
        frame(48'ha0_1234, 24, 1'b1, 2'h0, 16'h0, 1'b0);
        frame(48'h00_0000, 24, 1'b1, 2'h0, 16'h0, 1'b0);
        chk(rx[15:0], 16'h002a);
        chk({8'h0, rx[23:16]}, 16'h00a0);
        chk({10'h0, chan_out[0].fine_gain}, 16'h002a);
        frame(48'h18_0002, 24, 1'b1, 2'h0, 16'h0, 1'b0);
        frame(48'h28_00c3, 24, 1'b1, 2'h0, 16'h0, 1'b0);
        chk({14'h0, chan_out[0].coarse_gain}, 16'h0002);
        chk({8'h0, chan_out[0].offset}, 16'h00c3);
        frame(48'h01_0001, 24, 1'b1, 2'h1, 16'h0, 1'b0);
        chk({10'h0, func_bits}, 16'h0001);
        frame(48'h01_0000, 24, 1'b1, 2'h1, 16'h0, 1'b0);
        chk({10'h0, func_bits}, 16'h0000);
        clear_n = 1'b0;
        repeat (6) @(negedge clk);
        chk(chan_out[2].code, flip(16'h0));
        clear_n = 1'b1;
        daisy_chain = 1'b1;
        repeat (4) @(negedge clk);
        d = 16'($random(seed));
        frame({24'h13_5a5a, 8'h12, d}, 48, 1'b1, 2'h2, flip(d), 1'b1);
        chk(rx[23:8], 16'h135a);
        // second power-up with clear held low: outputs come up driven
        load_update_n = 1'b1;
        clear_n = 1'b0;
        rst_n = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        chk({15'h0, chan_out[3].clamp}, 16'h0);
        chk(chan_out[3].code, flip(16'h0));
        clear_n = 1'b1;
        wrap_up();
    end
endmodule : test_quad_dac_serial_control
`default_nettype wire
